//--- pqu_pkg.sv
// Shared types, constants and arithmetic helpers of the product/quotient unit.
// Assumes a single pipeline clock; no software-visible registers exist.
package pqu_pkg;

  localparam int          PQU_DATA_W     = 32;
  localparam int          PQU_PASS_W     = 16;
  localparam logic [63:0] PQU_HILO_RST   = 64'h0;
  localparam logic [31:0] PQU_WORD_RST   = 32'h0;
  // Divide latency in pipeline clocks per dividend class (12, 19, 26, 33)
  localparam logic [5:0]  PQU_DIV_LAT_8  = 6'h0c;
  localparam logic [5:0]  PQU_DIV_LAT_16 = 6'h13;
  localparam logic [5:0]  PQU_DIV_LAT_24 = 6'h1a;
  localparam logic [5:0]  PQU_DIV_LAT_32 = 6'h21;
  // Count left at which a multiply may issue behind a divide (repeat = latency - 1)
  localparam logic [5:0]  PQU_DIV_OVERLAP = 6'h02;

  typedef enum logic [4:0]
  {
    PQU_WIDE_PRODUCT_OP       = 5'h01,
    PQU_PRODUCT_ACCUMULATE_OP = 5'h02,
    PQU_PRODUCT_DEDUCT_OP     = 5'h04,
    PQU_GPR_PRODUCT_OP        = 5'h08,
    PQU_QUOTIENT_OP           = 5'h10
  } pqu_op_t;

  typedef enum logic [2:0]
  {
    PQU_MS_EMPTY  = 3'h1,
    PQU_MS_FIRST  = 3'h2,
    PQU_MS_SECOND = 3'h4
  } pqu_mstate_t;

  // Radix-4 recoded 33x17 signed multiply, one pass of the array
  function automatic logic signed [49:0] pqu_booth(input logic [32:0] a, input logic [16:0] b);
    logic [49:0] acc;
    logic [49:0] ae;
    logic [49:0] pp;
    logic [18:0] bx;
    acc = '0;
    ae  = {{17{a[32]}}, a};
    bx  = {b[16], b, 1'b0};
    for (int i = 0; i < 9; i++)
    begin
      case (bx[2*i +: 3])
        3'h1, 3'h2: pp = ae;
        3'h3:       pp = ae << 1;
        3'h4:       pp = 50'(-(ae << 1));
        3'h5, 3'h6: pp = 50'(-ae);
        default:    pp = '0;
      endcase
      acc = 50'(acc + (pp << (2 * i)));
    end
    return acc;
  endfunction

  // Dividend class: 0..3 for 8, 16, 24, 32 significant bits
  function automatic logic [1:0] pqu_div_class(input logic [31:0] d, input logic sgn);
    logic s;
    s = sgn & d[31];
    // Unsigned dividends only need the upper bits clear, not a spare sign bit
    if (sgn ? (d[31:7] == {25{s}}) : (d[31:8] == 24'h0))
      return 2'h0;
    else if (sgn ? (d[31:15] == {17{s}}) : (d[31:16] == 16'h0))
      return 2'h1;
    else if (sgn ? (d[31:23] == {9{s}}) : (d[31:24] == 8'h0))
      return 2'h2;
    else
      return 2'h3;
  endfunction

endpackage

//--- pqu_div_if.sv
// Connection between the issue/result logic and the divide engine.
// Both ends run on the one pipeline clock.
`timescale 1ns/10ps
interface pqu_div_if;
  logic        start;
  logic        is_signed;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        active;
  logic        mul_ok;
  logic        done;
  logic [31:0] quotient;
  logic [31:0] remainder;

  modport core   (output start, is_signed, dividend, divisor,
                  input  active, mul_ok, done, quotient, remainder);
  modport engine (input  start, is_signed, dividend, divisor,
                  output active, mul_ok, done, quotient, remainder);
endinterface

//--- pqu_divider.sv
// One-bit-per-clock restoring divider with early-in on narrow dividends.
// Assumes start is raised only while active is low.
`timescale 1ns/10ps
module pqu_divider
  import pqu_pkg::*;
(
  input  logic      ref_clk_in,
  input  logic      reset_in,
  pqu_div_if.engine div_io
);

  logic        active_reg, active_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic [5:0]  iter_reg, iter_next;
  logic [32:0] rem_reg, rem_next;
  logic [31:0] quo_reg, quo_next;
  logic [31:0] dvs_reg, dvs_next;
  logic        neg_q_reg, neg_q_next;
  logic        neg_r_reg, neg_r_next;

  always_comb
  begin
    logic [31:0] mag_a;
    logic [31:0] mag_b;
    logic [1:0]  cls;
    logic [32:0] shifted;
    mag_a = (div_io.is_signed && div_io.dividend[31]) ? 32'(-div_io.dividend) : div_io.dividend;
    mag_b = (div_io.is_signed && div_io.divisor[31]) ? 32'(-div_io.divisor) : div_io.divisor;
    cls   = pqu_div_class(div_io.dividend, div_io.is_signed);
    shifted     = {rem_reg[31:0], quo_reg[31]};
    active_next = active_reg;
    cnt_next    = cnt_reg;
    iter_next   = iter_reg;
    rem_next    = rem_reg;
    quo_next    = quo_reg;
    dvs_next    = dvs_reg;
    neg_q_next  = neg_q_reg;
    neg_r_next  = neg_r_reg;
    if (div_io.start)
    begin
      active_next = 1'b1;
      rem_next    = '0;
      dvs_next    = mag_b;
      neg_q_next  = div_io.is_signed & (div_io.dividend[31] ^ div_io.divisor[31]);
      neg_r_next  = div_io.is_signed & div_io.dividend[31];
      // Skip 24, 16 or 8 leading iterations by pre-aligning the dividend
      case (cls)
        2'h0:    begin iter_next = 6'h08; quo_next = mag_a << 24; cnt_next = PQU_DIV_LAT_8;  end
        2'h1:    begin iter_next = 6'h10; quo_next = mag_a << 16; cnt_next = PQU_DIV_LAT_16; end
        2'h2:    begin iter_next = 6'h18; quo_next = mag_a << 8;  cnt_next = PQU_DIV_LAT_24; end
        default: begin iter_next = 6'h20; quo_next = mag_a;       cnt_next = PQU_DIV_LAT_32; end
      endcase
    end
    else if (active_reg)
    begin
      cnt_next = cnt_reg - 6'h01;
      if (cnt_reg == 6'h01)
        active_next = 1'b0;
      if (iter_reg != 6'h00)
      begin
        // One quotient bit per clock
        iter_next = iter_reg - 6'h01;
        if (shifted >= {1'b0, dvs_reg})
        begin
          rem_next = 33'(shifted - {1'b0, dvs_reg});
          quo_next = {quo_reg[30:0], 1'b1};
        end
        else
        begin
          rem_next = shifted;
          quo_next = {quo_reg[30:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      active_reg <= 1'b0;
      cnt_reg    <= 6'h00;
      iter_reg   <= 6'h00;
      rem_reg    <= 33'h0;
      quo_reg    <= 32'h0;
      dvs_reg    <= 32'h0;
      neg_q_reg  <= 1'b0;
      neg_r_reg  <= 1'b0;
    end
    else
    begin
      active_reg <= active_next;
      cnt_reg    <= cnt_next;
      iter_reg   <= iter_next;
      rem_reg    <= rem_next;
      quo_reg    <= quo_next;
      dvs_reg    <= dvs_next;
      neg_q_reg  <= neg_q_next;
      neg_r_reg  <= neg_r_next;
    end
  end

  assign div_io.active    = active_reg;
  assign div_io.done      = active_reg && (cnt_reg == 6'h01);
  assign div_io.mul_ok    = !active_reg || (cnt_reg <= PQU_DIV_OVERLAP);
  assign div_io.quotient  = neg_q_reg ? 32'(-quo_reg) : quo_reg;
  assign div_io.remainder = neg_r_reg ? 32'(-rem_reg[31:0]) : rem_reg[31:0];

endmodule // pqu_divider

//--- pqu_product_quotient_unit.sv
// Product/quotient unit: multiply pipeline, result word pair and divide engine.
// Assumes the integer_pipeline holds its operation while busy_out is high.
//
// Operation
// - Multiply and divide run in their own pipeline beside the integer pipeline.
// - Work in flight keeps advancing while the integer pipeline stalls.
// - Recoded 32x16 multiplier, upper and bottom result words, divide engine.
// - Number of multiplier passes is chosen from the right operand value and its signedness only.
// - Right operand fitting 16 bits takes one pass; full 32x32 takes two.
// - Short multiplies issue every clock; full ones every second clock.
// - Back-to-back full multiplies stall issue; the pipeline holds the second one.
// - Division retires one quotient bit per clock.
// - Dividend sign extension skips 24, 16 or 8 iterations.
// - A divide during an active divide stalls until it ends; a multiply stalls until two divide clocks remain.
// - Result-pair multiplies: latency and repeat 1 for short, 2 for full.
// - Register-writing multiply: latency 2/repeat 1 short, latency 3/repeat 2 full.
// - Divides take 12/11, 19/18, 26/25, 33/32 clocks by dividend width.
`timescale 1ns/10ps
module pqu_product_quotient_unit
(
  input  logic             ref_clk_in,
  input  logic             reset_in,
  input  logic             op_valid_in,
  input  pqu_pkg::pqu_op_t op_code_in,
  input  logic             op_signed_in,
  input  logic [31:0]      left_operand_in,
  input  logic [31:0]      right_operand_in,
  output logic             busy_out,
  output logic [31:0]      result_upper_word_out,
  output logic [31:0]      result_bottom_word_out,
  output logic             gpr_valid_out,
  output logic [31:0]      gpr_data_out,
  output logic             div_active_out
);
  import pqu_pkg::*;

  pqu_div_if div_bus ();

  // Multiply stage state
  pqu_mstate_t mstate_reg, mstate_next;
  pqu_op_t     stg_op_reg, stg_op_next;
  logic [31:0] stg_a_reg, stg_a_next;
  logic [31:0] stg_b_reg, stg_b_next;
  logic        stg_sgn_reg, stg_sgn_next;
  logic        stg_long_reg, stg_long_next;
  logic [49:0] part_reg, part_next;

  // Result words and register-write path
  logic [63:0] hilo_reg, hilo_next;
  logic        gpr_mid_valid_reg, gpr_mid_valid_next;
  logic [31:0] gpr_mid_reg, gpr_mid_next;
  logic        gpr_valid_reg, gpr_valid_next;
  logic [31:0] gpr_data_reg, gpr_data_next;

  // Issue side
  logic        is_mul_in;
  logic        long_in;
  logic        stage_freeze;
  logic        stage_free;
  logic        accept;

  // Datapath
  logic [32:0] a33;
  logic [16:0] b_lo17;
  logic [16:0] b_hi17;
  logic [16:0] pass_b;
  logic [49:0] booth_out;
  logic [63:0] product;
  logic        finish;

  pqu_divider u_divider
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .div_io     (div_bus.engine)
  );

  // Issue control
  always_comb
  begin
    is_mul_in = (op_code_in != PQU_QUOTIENT_OP);
    // Pass count is decided from the right operand and op_signed_in alone
    if (op_signed_in)
      long_in = (right_operand_in[31:15] != {17{right_operand_in[31]}});
    else
      long_in = (right_operand_in[31:16] != 16'h0000);
    // The divide owns the result words on its final edge, so the stage waits
    stage_freeze = div_bus.done && (mstate_reg != PQU_MS_EMPTY);
    stage_free   = !stage_freeze &&
                   !((mstate_reg == PQU_MS_FIRST) && stg_long_reg);
    if (is_mul_in)
      busy_out = !stage_free || !div_bus.mul_ok;
    else
      busy_out = div_bus.active;
    accept = op_valid_in && !busy_out;
  end

  assign div_bus.start     = accept && !is_mul_in;
  assign div_bus.is_signed = op_signed_in;
  assign div_bus.dividend  = left_operand_in;
  assign div_bus.divisor   = right_operand_in;

  // One pass through the 32x16 array per clock
  always_comb
  begin
    a33       = {stg_sgn_reg & stg_a_reg[31], stg_a_reg};
    b_lo17    = stg_long_reg ? {1'b0, stg_b_reg[15:0]}
                             : {stg_sgn_reg & stg_b_reg[15], stg_b_reg[15:0]};
    b_hi17    = {stg_sgn_reg & stg_b_reg[31], stg_b_reg[31:16]};
    pass_b    = (mstate_reg == PQU_MS_SECOND) ? b_hi17 : b_lo17;
    booth_out = pqu_booth(a33, pass_b);
    if (mstate_reg == PQU_MS_SECOND)
      product = 64'({{14{part_reg[49]}}, part_reg} +
                    ({{14{booth_out[49]}}, booth_out} << PQU_PASS_W));
    else
      product = {{14{booth_out[49]}}, booth_out};
    finish = !stage_freeze &&
             (((mstate_reg == PQU_MS_FIRST) && !stg_long_reg) ||
              (mstate_reg == PQU_MS_SECOND));
  end

  // Stage sequencing, independent of integer pipeline stalls
  always_comb
  begin
    mstate_next   = mstate_reg;
    stg_op_next   = stg_op_reg;
    stg_a_next    = stg_a_reg;
    stg_b_next    = stg_b_reg;
    stg_sgn_next  = stg_sgn_reg;
    stg_long_next = stg_long_reg;
    part_next     = part_reg;
    if (!stage_freeze)
    begin
      case (mstate_reg)
        PQU_MS_EMPTY:
          mstate_next = PQU_MS_EMPTY;
        PQU_MS_FIRST:
        begin
          if (stg_long_reg)
          begin
            mstate_next = PQU_MS_SECOND;
            part_next   = booth_out;
          end
          else
            mstate_next = PQU_MS_EMPTY;
        end
        PQU_MS_SECOND:
          mstate_next = PQU_MS_EMPTY;
        default:
          mstate_next = PQU_MS_EMPTY;
      endcase
    end
    if (accept && is_mul_in)
    begin
      // A multiply of either length can enter while the previous one retires
      mstate_next   = PQU_MS_FIRST;
      stg_op_next   = op_code_in;
      stg_a_next    = left_operand_in;
      stg_b_next    = right_operand_in;
      stg_sgn_next  = op_signed_in;
      stg_long_next = long_in;
    end
  end

  // Result words and the register-write output
  always_comb
  begin
    hilo_next          = hilo_reg;
    gpr_mid_valid_next = 1'b0;
    gpr_mid_next       = gpr_mid_reg;
    gpr_valid_next     = gpr_mid_valid_reg;
    gpr_data_next      = gpr_mid_valid_reg ? gpr_mid_reg : gpr_data_reg;
    if (div_bus.done)
      hilo_next = {div_bus.remainder, div_bus.quotient};
    else if (finish)
    begin
      case (stg_op_reg)
        PQU_WIDE_PRODUCT_OP:       hilo_next = product;
        PQU_PRODUCT_ACCUMULATE_OP: hilo_next = 64'(hilo_reg + product);
        PQU_PRODUCT_DEDUCT_OP:     hilo_next = 64'(hilo_reg - product);
        PQU_GPR_PRODUCT_OP:
        begin
          // Extra stage toward the register file adds one clock
          gpr_mid_valid_next = 1'b1;
          gpr_mid_next       = product[31:0];
        end
        default:                   hilo_next = hilo_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      mstate_reg        <= PQU_MS_EMPTY;
      stg_op_reg        <= PQU_WIDE_PRODUCT_OP;
      stg_a_reg         <= PQU_WORD_RST;
      stg_b_reg         <= PQU_WORD_RST;
      stg_sgn_reg       <= 1'b0;
      stg_long_reg      <= 1'b0;
      part_reg          <= 50'h0;
      hilo_reg          <= PQU_HILO_RST;
      gpr_mid_valid_reg <= 1'b0;
      gpr_mid_reg       <= PQU_WORD_RST;
      gpr_valid_reg     <= 1'b0;
      gpr_data_reg      <= PQU_WORD_RST;
    end
    else
    begin
      mstate_reg        <= mstate_next;
      stg_op_reg        <= stg_op_next;
      stg_a_reg         <= stg_a_next;
      stg_b_reg         <= stg_b_next;
      stg_sgn_reg       <= stg_sgn_next;
      stg_long_reg      <= stg_long_next;
      part_reg          <= part_next;
      hilo_reg          <= hilo_next;
      gpr_mid_valid_reg <= gpr_mid_valid_next;
      gpr_mid_reg       <= gpr_mid_next;
      gpr_valid_reg     <= gpr_valid_next;
      gpr_data_reg      <= gpr_data_next;
    end
  end

  assign result_upper_word_out  = hilo_reg[63:32];
  assign result_bottom_word_out = hilo_reg[31:0];
  assign gpr_valid_out          = gpr_valid_reg;
  assign gpr_data_out           = gpr_data_reg;
  assign div_active_out         = div_bus.active;

endmodule // pqu_product_quotient_unit

//--- pqu_properties.sv
// Port-level checks of the product/quotient unit.
// Assumes the issuing side holds an operation while busy_out is high.
`timescale 1ns/10ps
module pqu_properties
  import pqu_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  input wire logic        op_valid_in,
  input wire pqu_op_t     op_code_in,
  input wire logic        op_signed_in,
  input wire logic [31:0] left_operand_in,
  input wire logic [31:0] right_operand_in,
  input wire logic        busy_out,
  input wire logic [31:0] result_upper_word_out,
  input wire logic [31:0] result_bottom_word_out,
  input wire logic        gpr_valid_out,
  input wire logic [31:0] gpr_data_out,
  input wire logic        div_active_out
);
  logic take;
  logic short_op;
  logic mul_op;
  logic div_op;
  logic cls8;
  logic cls32;
  logic [31:0] l;
  logic [31:0] r;
  assign l = left_operand_in;
  assign r = right_operand_in;
  assign take = op_valid_in && !busy_out;
  assign short_op = op_signed_in ? (r[31:15] == {17{r[15]}}) : (r[31:16] == 16'h0);
  // A multiply taken beside a running divide may be frozen, so its timing is left out
  assign mul_op = take && !div_active_out && (op_code_in != PQU_QUOTIENT_OP);
  assign div_op = take && (op_code_in == PQU_QUOTIENT_OP);
  assign cls8 = op_signed_in ? (l[31:7] == {25{l[31]}}) : (l[31:8] == 24'h0);
  assign cls32 = op_signed_in ? (l[31:23] != {9{l[31]}}) : (l[31:24] != 8'h0);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Results written on the edge after the latency are seen one sample later
  gpr_short_a: assert property (mul_op && short_op && op_code_in == PQU_GPR_PRODUCT_OP
    |-> ##3 gpr_valid_out) else $error("short register product late");
  gpr_long_a: assert property (mul_op && !short_op && op_code_in == PQU_GPR_PRODUCT_OP
    |-> ##3 !gpr_valid_out ##1 gpr_valid_out) else $error("long register product timing");
  long_busy_a: assert property (mul_op && !short_op
    |=> busy_out || op_code_in == PQU_QUOTIENT_OP) else $error("long multiply not interlocked");
  short_free_a: assert property (mul_op && short_op |=> !busy_out)
    else $error("short multiply stalled issue");
  div_busy_a: assert property (div_active_out && op_code_in == PQU_QUOTIENT_OP |-> busy_out)
    else $error("divide taken during divide");
  div_start_a: assert property (div_op |=> div_active_out) else $error("divide not started");
  div_short_a: assert property (div_op && cls8 |-> ##12 div_active_out ##1 !div_active_out)
    else $error("narrow divide length wrong");
  div_full_a: assert property (div_op && cls32 |-> ##33 div_active_out ##1 !div_active_out)
    else $error("full divide length wrong");
  lo_short_a: assert property (mul_op && short_op && op_code_in == PQU_WIDE_PRODUCT_OP
    |-> ##2 result_bottom_word_out == 32'($past(l, 2) * $past(r, 2)))
    else $error("short product wrong");
  lo_long_a: assert property (mul_op && !short_op && op_code_in == PQU_WIDE_PRODUCT_OP
    |-> ##3 result_bottom_word_out == 32'($past(l, 3) * $past(r, 3)))
    else $error("long product");
  cover property (mul_op && !short_op && op_code_in == PQU_GPR_PRODUCT_OP);
  cover property (div_op && cls32);
  cover property (op_valid_in && busy_out && div_active_out);
endmodule // pqu_properties
bind pqu_product_quotient_unit pqu_properties chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .op_valid_in(op_valid_in), .op_code_in(op_code_in), .op_signed_in(op_signed_in),
  .left_operand_in(left_operand_in), .right_operand_in(right_operand_in), .busy_out(busy_out),
  .result_upper_word_out(result_upper_word_out), .result_bottom_word_out(result_bottom_word_out),
  .gpr_valid_out(gpr_valid_out), .gpr_data_out(gpr_data_out), .div_active_out(div_active_out));

//--- pqu_issue_model.sv
// Integer pipeline stand-in: offers queued operations, holds each while busy.
// Assumes one clock shared with the unit; bubbles in the queue slow issue.
`timescale 1ns/10ps
module pqu_issue_model
(
  input  wire logic         ref_clk_in,
  input  wire logic         reset_in,
  input  wire logic         busy_in,
  output logic              op_valid_out,
  output pqu_pkg::pqu_op_t  op_code_out,
  output logic              op_signed_out,
  output logic [31:0]       left_out,
  output logic [31:0]       right_out,
  output logic              idle_out
);
  import pqu_pkg::*;
  typedef struct { logic v; pqu_op_t c; logic s; logic [31:0] a; logic [31:0] b; } pqu_req_t;
  pqu_req_t q[$];
  logic     shown = 1'b0;
  task automatic push(logic v, pqu_op_t c, logic s, logic [31:0] a, logic [31:0] b);
    q.push_back('{v, c, s, a, b});
  endtask
  initial
  begin
    op_valid_out = 1'b0;
    op_code_out = PQU_WIDE_PRODUCT_OP;
    op_signed_out = 1'b0;
    left_out = 32'h0;
    right_out = 32'h0;
    idle_out = 1'b1;
  end
  always @(posedge ref_clk_in)
  begin
    if (shown && !reset_in && (!q[0].v || !busy_in))
      void'(q.pop_front());
    #1;
    shown = q.size() > 0;
    op_valid_out = shown && q[0].v;
    idle_out = !shown;
    // Idle operand lines toggle so a stale value is never read as valid
    left_out = shown ? q[0].a : ~left_out;
    right_out = shown ? q[0].b : ~right_out;
    if (shown)
    begin
      op_code_out = q[0].c;
      op_signed_out = q[0].s;
    end
  end
endmodule // pqu_issue_model

//--- tb.sv
// Self-checking bench of the product/quotient unit with an issuing model.
// Expected results come from a plain 64-bit reference computed here.
`timescale 1ns/10ps
module tb;
  import pqu_pkg::*;
  typedef struct { pqu_op_t c; logic s; logic [31:0] a; logic [31:0] b; int lat; } pqu_row_t;
  logic clk, rst, op_valid, op_signed, busy, gv, dact, idle;
  pqu_op_t op_code;
  logic [31:0] left, right, hi, lo, gd, g;
  logic [63:0] m;
  int miscompares = 0, total_checks = 0, act_cnt = 0, bc = 0, gvc = 0;
  pqu_row_t rows[10] = '{
    '{PQU_WIDE_PRODUCT_OP, 1'b0, 32'h12345678, 32'h00001234, 0},
    '{PQU_WIDE_PRODUCT_OP, 1'b1, 32'hfffffff0, 32'h12345678, 0},
    '{PQU_PRODUCT_ACCUMULATE_OP, 1'b1, 32'h00000005, 32'hfffffffd, 0},
    '{PQU_PRODUCT_DEDUCT_OP, 1'b0, 32'h00010000, 32'h00010000, 0},
    '{PQU_GPR_PRODUCT_OP, 1'b1, 32'h7fffffff, 32'h7fffffff, 0},
    '{PQU_QUOTIENT_OP, 1'b1, 32'hffffff9c, 32'h00000007, 12},
    '{PQU_QUOTIENT_OP, 1'b0, 32'h0000abcd, 32'h00000013, 19},
    '{PQU_QUOTIENT_OP, 1'b1, 32'h00123456, 32'hfffffffb, 26},
    '{PQU_QUOTIENT_OP, 1'b0, 32'hfedcba98, 32'h00000003, 33},
    '{PQU_GPR_PRODUCT_OP, 1'b0, 32'h89abcdef, 32'h00000010, 0}};
  pqu_issue_model host (.ref_clk_in(clk), .reset_in(rst), .busy_in(busy), .op_valid_out(op_valid),
    .op_code_out(op_code), .op_signed_out(op_signed), .left_out(left), .right_out(right),
    .idle_out(idle));
  pqu_product_quotient_unit uut (.ref_clk_in(clk), .reset_in(rst), .op_valid_in(op_valid),
    .op_code_in(op_code), .op_signed_in(op_signed), .left_operand_in(left),
    .right_operand_in(right), .busy_out(busy), .result_upper_word_out(hi),
    .result_bottom_word_out(lo), .gpr_valid_out(gv), .gpr_data_out(gd), .div_active_out(dact));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (dact)
      act_cnt++;
    if (op_valid && busy)
      bc++;
    if (gv)
      gvc++;
  end
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic model_op(pqu_op_t c, logic s, logic [31:0] a, logic [31:0] b);
    logic [63:0] p;
    p = (s ? {{32{a[31]}}, a} : {32'h0, a}) * (s ? {{32{b[31]}}, b} : {32'h0, b});
    case (c)
      PQU_WIDE_PRODUCT_OP:       m = p;
      PQU_PRODUCT_ACCUMULATE_OP: m = m + p;
      PQU_PRODUCT_DEDUCT_OP:     m = m - p;
      PQU_GPR_PRODUCT_OP:        g = p[31:0];
      default: m = s ? {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))} : {a % b, a / b};
    endcase
  endtask
  task automatic issue(pqu_op_t c, logic s, logic [31:0] a, logic [31:0] b);
    host.push(1'b1, c, s, a, b);
    model_op(c, s, a, b);
  endtask
  task automatic settle();
    @(posedge clk);
    #2;
    for (int i = 0; i < 200 && !(idle && !dact); i++)
    begin
      @(posedge clk);
      #2;
    end
    repeat (4) @(posedge clk);
    #2;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    complete_run();
  end
  initial
  begin
    rst = 1'b1;
    m = 64'h0;
    g = 32'h0;
    repeat (20) @(posedge clk);
    #2;
    check("reset words", {hi, lo}, 64'h0);
    check("reset flags", {61'h0, busy, gv, dact}, 64'h0);
    @(posedge clk);
    #1;
    rst = 1'b0;
    $display("test reset done");
    foreach (rows[i])
    begin
      act_cnt = 0;
      gvc = 0;
      issue(rows[i].c, rows[i].s, rows[i].a, rows[i].b);
      settle();
      check("result pair", {hi, lo}, m);
      check("register word", {32'h0, gd}, {32'h0, g});
      check("register pulses", 64'(gvc), 64'(rows[i].c == PQU_GPR_PRODUCT_OP));
      check("divide cycles", 64'(act_cnt), 64'(rows[i].lat));
      $display("test row %0d done", i);
    end
    bc = 0;
    issue(PQU_WIDE_PRODUCT_OP, 1'b0, 32'h00000007, 32'h12345678);
    issue(PQU_WIDE_PRODUCT_OP, 1'b1, 32'h80000001, 32'h12345678);
    settle();
    check("long stall", 64'(bc), 64'h1);
    check("long pair", {hi, lo}, m);
    bc = 0;
    for (int k = 1; k < 4; k++)
      issue(PQU_WIDE_PRODUCT_OP, 1'b1, 32'(k), 32'hffff8000);
    settle();
    check("short stall", 64'(bc), 64'h0);
    check("short pair", {hi, lo}, m);
    $display("test multiply rate done");
    bc = 0;
    issue(PQU_QUOTIENT_OP, 1'b1, 32'hffffff9c, 32'h00000007);
    issue(PQU_WIDE_PRODUCT_OP, 1'b0, 32'h00000003, 32'h00000005);
    settle();
    check("multiply behind divide", 64'(bc), 64'ha);
    check("pair after overlap", {hi, lo}, m);
    bc = 0;
    act_cnt = 0;
    issue(PQU_QUOTIENT_OP, 1'b1, 32'hffffff9c, 32'h00000007);
    issue(PQU_QUOTIENT_OP, 1'b0, 32'h000000f0, 32'h00000009);
    settle();
    check("divide behind divide", 64'(bc), 64'hc);
    check("two divide cycles", 64'(act_cnt), 64'h18);
    check("second quotient", {hi, lo}, m);
    $display("test divide interlock done");
    issue(PQU_QUOTIENT_OP, 1'b0, 32'hfedcba98, 32'h00000003);
    repeat (8) @(posedge clk);
    #1;
    check("divide running", {63'h0, dact}, 64'h1);
    rst = 1'b1;
    #3;
    check("reset mid divide", {63'h0, dact}, 64'h0);
    check("reset clears pair", {hi, lo}, 64'h0);
    @(posedge clk);
    #1;
    rst = 1'b0;
    $display("test reset in divide done");
    complete_run();
  end
endmodule // tb
